//--- design/sdcp_decode.sv
`timescale 1ns/10ps
// Functional notes
// R1: bank select pins pick bank 0..3, high pin is the upper bit
// R2: activation captures all twelve address bits as the row address
// R3: read/write take column from low nine bits, bit ten asks auto precharge
// R4: bank, row and column index exactly one stored word
// R5: precharge with bit ten high closes every bank
// R6: mode set loads the operating code from the address pins
// R7: any edge with chip select high is ignored
// R8: strobes and write enable are registered each edge, decoded together
// R9: select, row strobe low, others high opens the selected bank
// R10: select, row strobe low, column high, write low precharges to idle
// R11: select low, row high, column low starts write or read by write enable
// R12: masks turn off read drivers and block masked write bytes
// R13: data moves on rising edges with per-lane masking
// R14: controller deselects or sends no-operation when it has no command
module sdcp_decode
    import sdcp_pkg::*;
#(
    parameter int STORE_ROW_W = ROW_W,
    parameter int STORE_COL_W = COL_W
) (
    input wire logic CLK_SYS_I,
    input wire logic RST_N_I,
    input wire logic CS_N_I,
    input wire logic ROW_STROBE_N_I,
    input wire logic COL_STROBE_N_I,
    input wire logic WRITE_EN_N_I,
    input wire logic BANK_SEL_LO_I,
    input wire logic BANK_SEL_HI_I,
    input wire logic [ADDR_W-1:0] ADDRESS_BUS_I,
    input wire logic LOWER_BYTE_MASK_I,
    input wire logic UPPER_BYTE_MASK_I,
    input wire logic [DATA_W-1:0] DATA_LINES_I,
    output logic [DATA_W-1:0] DATA_LINES_O,
    output logic [LANES-1:0] DATA_LINES_OE_O,
    output logic [BANKS-1:0] BANK_ACTIVE_O,
    output logic [ADDR_W-1:0] MODE_CODE_O
);

    localparam int LOC_W = BANK_W + STORE_ROW_W + STORE_COL_W;

    // ***************************************************************
    // decode helpers
    // ***************************************************************
    // R1: bank one-hot
    function automatic logic [BANKS-1:0] bank_onehot(input logic [BANK_W-1:0] b);
        bank_onehot = '0;
        bank_onehot[b] = 1'b1;
    endfunction

    // R8: joint strobe decode
    function automatic sdcp_cmd_e cmd_decode(input sdcp_pins_s p);
        logic [2:0] s;
        s = {p.row_strobe_n, p.col_strobe_n, p.write_en_n};
        // R7: deselect masks all
        if (p.cs_n) begin
            cmd_decode = CMD_DESELECT;
        end else begin
            unique case (s)
                3'h3: cmd_decode = CMD_ROW_OPEN;
                3'h2: cmd_decode = CMD_PRECHARGE;
                3'h5: cmd_decode = CMD_READ;
                3'h4: cmd_decode = CMD_WRITE;
                3'h0: cmd_decode = CMD_MODE_SET;
                3'h7: cmd_decode = CMD_NOP;
                default: cmd_decode = CMD_OTHER;
            endcase
        end
    endfunction

    // ***************************************************************
    // reset release
    // ***************************************************************
    logic [1:0] rst_sync_ff;
    logic rst_n;

    // two flops so the release is clean against the clock
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rst_sync_ff <= SYNC_RST;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    // ***************************************************************
    // pin sampling
    // ***************************************************************
    sdcp_pins_s pins_ff;
    sdcp_pins_s nxt_pins;
    sdcp_cmd_e cmd;

    // R8: gather pins of this edge
    always_comb begin
        nxt_pins.cs_n = CS_N_I;
        nxt_pins.row_strobe_n = ROW_STROBE_N_I;
        nxt_pins.col_strobe_n = COL_STROBE_N_I;
        nxt_pins.write_en_n = WRITE_EN_N_I;
        nxt_pins.bank = {BANK_SEL_HI_I, BANK_SEL_LO_I};
        nxt_pins.addr = ADDRESS_BUS_I;
        nxt_pins.mask = {UPPER_BYTE_MASK_I, LOWER_BYTE_MASK_I};
        nxt_pins.data = DATA_LINES_I;
    end

    // idle pins after reset decode as deselect
    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            pins_ff <= '{cs_n: 1'b1, row_strobe_n: 1'b1, col_strobe_n: 1'b1,
                         write_en_n: 1'b1, default: '0};
        end else begin
            pins_ff <= nxt_pins;
        end
    end

    assign cmd = cmd_decode(pins_ff);

    // ***************************************************************
    // bank state, mode code and data path
    // ***************************************************************
    logic [BANKS-1:0] active_ff;
    logic [BANKS-1:0] nxt_active;
    logic [ROW_W-1:0] row_ff [BANKS];
    logic [ROW_W-1:0] nxt_row [BANKS];
    logic [ADDR_W-1:0] mode_ff;
    logic [ADDR_W-1:0] nxt_mode;
    logic [DATA_W-1:0] dout_ff;
    logic [DATA_W-1:0] nxt_dout;
    logic [LANES-1:0] oe_ff;
    logic [LANES-1:0] nxt_oe;
    logic [BANKS-1:0] sel;
    logic bank_open;
    logic auto_pre;
    logic wr_en;
    logic [LOC_W-1:0] loc_idx;
    logic [DATA_W-1:0] rd_data;

    assign sel = bank_onehot(pins_ff.bank);
    assign bank_open = active_ff[pins_ff.bank];
    assign auto_pre = pins_ff.addr[AP_BIT];

    // R4: bank, open row and column form one word index
    assign loc_idx = {pins_ff.bank, row_ff[pins_ff.bank][STORE_ROW_W-1:0],
                      pins_ff.addr[STORE_COL_W-1:0]};

    // command effects; accesses to a closed bank are dropped
    always_comb begin
        nxt_active = active_ff;
        nxt_row = row_ff;
        nxt_mode = mode_ff;
        nxt_dout = dout_ff;
        nxt_oe = OE_RST;
        wr_en = 1'b0;
        unique case (cmd)
            // R9: open an idle bank
            CMD_ROW_OPEN: begin
                if (!bank_open) begin
                    nxt_active = active_ff | sel;
                    // R2: latch the row
                    nxt_row[pins_ff.bank] = pins_ff.addr;
                end
            end
            // R10: close one bank, or R5 all
            CMD_PRECHARGE: begin
                if (auto_pre) begin
                    nxt_active = ACTIVE_RST;
                end else begin
                    nxt_active = active_ff & ~sel;
                end
            end
            // R11: read access
            CMD_READ: begin
                if (bank_open) begin
                    nxt_dout = rd_data;
                    // R12: mask turns drivers off
                    nxt_oe = ~pins_ff.mask;
                    // R3: auto precharge after access
                    if (auto_pre) begin
                        nxt_active = active_ff & ~sel;
                    end
                end
            end
            // R11: write access
            CMD_WRITE: begin
                if (bank_open) begin
                    wr_en = 1'b1;
                    // R3: auto precharge after access
                    if (auto_pre) begin
                        nxt_active = active_ff & ~sel;
                    end
                end
            end
            // R6: load operating code
            CMD_MODE_SET: nxt_mode = pins_ff.addr;
            CMD_NOP, CMD_OTHER, CMD_DESELECT: ;
        endcase
    end

    // row latches carry no reset: only valid while the bank is open
    always_ff @(posedge CLK_SYS_I) begin
        row_ff <= nxt_row;
    end

    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            active_ff <= ACTIVE_RST;
            mode_ff <= MODE_RST;
            dout_ff <= DOUT_RST;
            oe_ff <= OE_RST;
        end else begin
            active_ff <= nxt_active;
            mode_ff <= nxt_mode;
            dout_ff <= nxt_dout;
            oe_ff <= nxt_oe;
        end
    end

    // R12: lane enables block masked write bytes
    sdcp_store #(
        .LOC_W(LOC_W),
        .LANE_W(LANE_W),
        .LANES(LANES)
    ) u_store (
        .clk_i(CLK_SYS_I),
        .wr_en_i(wr_en),
        .lane_en_i(~pins_ff.mask),
        .idx_i(loc_idx),
        .wdata_i(pins_ff.data),
        .rdata_o(rd_data)
    );

    // R13: all outputs leave from rising-edge flops
    assign DATA_LINES_O = dout_ff;
    assign DATA_LINES_OE_O = oe_ff;
    assign BANK_ACTIVE_O = active_ff;
    assign MODE_CODE_O = mode_ff;

    // ***************************************************************
    // checks
    // ***************************************************************
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!rst_n);

    sequence s_open_idle;
        cmd == CMD_ROW_OPEN && !bank_open;
    endsequence

    sequence s_read_open;
        cmd == CMD_READ && bank_open;
    endsequence

    // the first edge out of reset still holds the reset copy, so skip it
    a_pins_sampled: assert property ( // R8
        $past(rst_n) |-> pins_ff == $past(nxt_pins))
        else $error("pins not registered on the edge");

    a_bank_opens: assert property ( // R9
        s_open_idle |=> BANK_ACTIVE_O[$past(pins_ff.bank)])
        else $error("activate did not open bank");

    a_row_latched: assert property ( // R2
        s_open_idle |=> row_ff[$past(pins_ff.bank)] == $past(pins_ff.addr))
        else $error("row address not captured");

    a_one_precharge: assert property ( // R10
        cmd == CMD_PRECHARGE && !auto_pre
        |=> BANK_ACTIVE_O == ($past(active_ff) & ~$past(sel)))
        else $error("single bank precharge wrong");

    a_all_precharge: assert property ( // R5
        cmd == CMD_PRECHARGE && auto_pre |=> BANK_ACTIVE_O == 4'h0)
        else $error("precharge all left a bank open");

    a_deselect_idle: assert property ( // R7
        pins_ff.cs_n |=> $stable(BANK_ACTIVE_O) && $stable(MODE_CODE_O)
                        && DATA_LINES_OE_O == 2'h0)
        else $error("deselected edge changed state");

    a_mode_loaded: assert property ( // R6
        cmd == CMD_MODE_SET |=> MODE_CODE_O == $past(pins_ff.addr))
        else $error("mode code not loaded");

    a_read_drive: assert property ( // R12
        s_read_open |=> DATA_LINES_OE_O == ~$past(pins_ff.mask)
                        && DATA_LINES_O == $past(rd_data))
        else $error("read drive or data wrong");

    a_auto_close: assert property ( // R3
        (cmd == CMD_READ || cmd == CMD_WRITE) && bank_open && auto_pre
        |=> !BANK_ACTIVE_O[$past(pins_ff.bank)])
        else $error("auto precharge did not close bank");

    a_drive_one_edge: assert property ( // R13
        DATA_LINES_OE_O != 2'h0 |-> $past(cmd) == CMD_READ)
        else $error("drivers on without a read");

endmodule

//--- design/sdcp_pkg.sv
package sdcp_pkg;

    // ***************************************************************
    // pin widths and address layout
    // ***************************************************************
    localparam int ADDR_W = 12;
    localparam int ROW_W = 12;
    localparam int COL_W = 9;
    localparam int DATA_W = 16;
    localparam int LANE_W = 8;
    localparam int LANES = 2;
    localparam int BANKS = 4;
    localparam int BANK_W = 2;
    localparam int AP_BIT = 10;

    // ***************************************************************
    // values after reset
    // ***************************************************************
    localparam logic [ADDR_W-1:0] MODE_RST = 12'h000;
    localparam logic [BANKS-1:0] ACTIVE_RST = 4'h0;
    localparam logic [1:0] SYNC_RST = 2'h0;
    localparam logic [LANES-1:0] OE_RST = 2'h0;
    localparam logic [DATA_W-1:0] DOUT_RST = 16'h0000;

    // decoded command of one sampled edge
    typedef enum logic [2:0] {
        CMD_DESELECT,
        CMD_NOP,
        CMD_ROW_OPEN,
        CMD_PRECHARGE,
        CMD_READ,
        CMD_WRITE,
        CMD_MODE_SET,
        CMD_OTHER
    } sdcp_cmd_e;

    // all command, address, mask and data pins of one edge
    typedef struct packed {
        logic cs_n;
        logic row_strobe_n;
        logic col_strobe_n;
        logic write_en_n;
        logic [BANK_W-1:0] bank;
        logic [ADDR_W-1:0] addr;
        logic [LANES-1:0] mask;
        logic [DATA_W-1:0] data;
    } sdcp_pins_s;

endpackage

//--- design/sdcp_store.sv
`timescale 1ns/10ps
module sdcp_store #(
    parameter int LOC_W = 23,
    parameter int LANE_W = 8,
    parameter int LANES = 2
) (
    input wire logic clk_i,
    input wire logic wr_en_i,
    input wire logic [LANES-1:0] lane_en_i,
    input wire logic [LOC_W-1:0] idx_i,
    input wire logic [LANES*LANE_W-1:0] wdata_i,
    output logic [LANES*LANE_W-1:0] rdata_o
);

    // ***************************************************************
    // one flop array per byte lane
    // ***************************************************************
    // separate arrays keep each lane single-driven under byte masks
    for (genvar g = 0; g < LANES; g++) begin : g_lane
        logic [LANE_W-1:0] mem [2**LOC_W];

        // lane write, blocked while its mask is high
        always_ff @(posedge clk_i) begin
            if (wr_en_i && lane_en_i[g]) begin
                mem[idx_i] <= wdata_i[g*LANE_W +: LANE_W];
            end
        end

        assign rdata_o[g*LANE_W +: LANE_W] = mem[idx_i];
    end

endmodule

//--- verification/sdcp_ctrl_model.sv
`timescale 1ns/10ps
// ***************************************************************
// controller model driving the command, address and data pins
// ***************************************************************
module sdcp_ctrl_model
    import sdcp_pkg::*;
(
    input wire logic clk_i,
    output sdcp_pins_s pins_o
);
    // idle no-operation
    // released data lines show the inverse of the last value
    task automatic idle();
        pins_o.cs_n = 1'b0;
        pins_o.row_strobe_n = 1'b1;
        pins_o.col_strobe_n = 1'b1;
        pins_o.write_en_n = 1'b1;
        pins_o.data = ~pins_o.data;
    endtask

    // one command per edge
    // returns before the sampling edge so the next call lands back to back
    task automatic cmd(input logic cs_n, input logic [2:0] rcw, input logic [1:0] bank,
                       input logic [11:0] addr, input logic [1:0] mask,
                       input logic [15:0] data);
        @(negedge clk_i);
        pins_o.cs_n = cs_n;
        {pins_o.row_strobe_n, pins_o.col_strobe_n, pins_o.write_en_n} = rcw;
        pins_o.bank = bank;
        pins_o.addr = addr;
        pins_o.mask = mask;
        pins_o.data = data;
    endtask

    // back to idle after the last command edge
    task automatic rest();
        @(negedge clk_i);
        idle();
    endtask

    // pins known from time zero
    initial begin
        pins_o = '0;
        idle();
    end
endmodule

//--- verification/sdcp_decode_tb.sv
`timescale 1ns/10ps
module sdcp_decode_tb;
    import sdcp_pkg::*;
    localparam logic [2:0] RO = 3'h3;
    localparam logic [2:0] PR = 3'h2;
    localparam logic [2:0] RD = 3'h5;
    localparam logic [2:0] WR = 3'h4;
    localparam logic [2:0] MS = 3'h0;
    localparam logic [2:0] RF = 3'h1;
    localparam logic [2:0] BS = 3'h6;
    logic clk_sys;
    logic rst_n;
    sdcp_pins_s pins;
    logic [DATA_W-1:0] dout;
    logic [LANES-1:0] oe;
    logic [BANKS-1:0] act;
    logic [ADDR_W-1:0] mode;
    int num_errors = 0;
    int checked = 0;

    // ***************************************************************
    // clock, design and controller
    // ***************************************************************
    initial clk_sys = 1'b0;
    always #50 clk_sys = ~clk_sys;

    // small storage keeps the model quick
    sdcp_decode #(.STORE_ROW_W(2), .STORE_COL_W(3)) sdcp_decode_i (
        .CLK_SYS_I(clk_sys), .RST_N_I(rst_n), .CS_N_I(pins.cs_n),
        .ROW_STROBE_N_I(pins.row_strobe_n), .COL_STROBE_N_I(pins.col_strobe_n),
        .WRITE_EN_N_I(pins.write_en_n), .BANK_SEL_LO_I(pins.bank[0]),
        .BANK_SEL_HI_I(pins.bank[1]), .ADDRESS_BUS_I(pins.addr),
        .LOWER_BYTE_MASK_I(pins.mask[0]), .UPPER_BYTE_MASK_I(pins.mask[1]),
        .DATA_LINES_I(pins.data), .DATA_LINES_O(dout), .DATA_LINES_OE_O(oe),
        .BANK_ACTIVE_O(act), .MODE_CODE_O(mode)
    );
    sdcp_ctrl_model sdcp_ctrl_model_i (.clk_i(clk_sys), .pins_o(pins));

    // ***************************************************************
    // compare, helper and closing tasks
    // ***************************************************************
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: word %h want %h", $time, got, exp);
        end
    endtask

    task automatic chk4(input logic [3:0] got, input logic [3:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: flags %b want %b", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        $display("checked %0d num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // results show one edge after the command edge
    task automatic after();
        sdcp_ctrl_model_i.rest();
        @(posedge clk_sys);
        #1;
    endtask

    task automatic op(input logic [2:0] rcw, input logic [1:0] b, input logic [11:0] a,
                      input logic [1:0] m, input logic [15:0] d);
        sdcp_ctrl_model_i.cmd(1'b0, rcw, b, a, m, d);
        after();
    endtask

    // read, then the drive enable must drop after one cycle
    task automatic rd(input logic [1:0] b, input logic [11:0] a, input logic [1:0] m,
                      input logic [15:0] exp);
        op(RD, b, a, m, 16'h0000);
        chk16(dout, exp);
        chk4({2'b00, oe}, {2'b00, ~m});
        @(posedge clk_sys);
        #1;
        chk4({2'b00, oe}, 4'h0);
    endtask

    // ***************************************************************
    // scenarios
    // ***************************************************************
    task automatic t_mode();
        chk4(act, 4'h0);
        chk16(dout, 16'h0000);
        op(MS, 2'b00, 12'h5a3, 2'b00, 16'h0000);
        chk16({4'h0, mode}, 16'h05a3);
        // deselected edges carrying real encodings
        sdcp_ctrl_model_i.cmd(1'b1, MS, 2'b00, 12'h0ff, 2'b00, 16'h0000);
        sdcp_ctrl_model_i.cmd(1'b1, RO, 2'b10, 12'h001, 2'b00, 16'h0000);
        after();
        chk16({4'h0, mode}, 16'h05a3);
        chk4(act, 4'h0);
        // refresh and burst stop codes fall outside this block and are refused
        sdcp_ctrl_model_i.cmd(1'b0, RF, 2'b00, 12'h0ff, 2'b00, 16'h0000);
        sdcp_ctrl_model_i.cmd(1'b0, BS, 2'b01, 12'h0ff, 2'b00, 16'h0000);
        after();
        chk16({4'h0, mode}, 16'h05a3);
        chk4(act, 4'h0);
        chk4({2'b00, oe}, 4'h0);
        $display("test mode done");
    endtask

    task automatic t_banks();
        logic [3:0] exp;
        exp = 4'h0;
        for (int b = 0; b < 4; b++) begin
            exp[b] = 1'b1;
            op(RO, 2'(b), 12'hc01, 2'b00, 16'h0000);
            chk4(act, exp);
        end
        $display("test banks done");
    endtask

    task automatic t_data();
        // back to back writes, last one with the lower lane masked
        sdcp_ctrl_model_i.cmd(1'b0, WR, 2'b00, 12'h001, 2'b00, 16'h1234);
        sdcp_ctrl_model_i.cmd(1'b0, WR, 2'b11, 12'h001, 2'b00, 16'hbeef);
        sdcp_ctrl_model_i.cmd(1'b0, WR, 2'b00, 12'h002, 2'b00, 16'h5566);
        sdcp_ctrl_model_i.cmd(1'b0, WR, 2'b00, 12'h001, 2'b01, 16'habcd);
        after();
        rd(2'b00, 12'h001, 2'b00, 16'hab34);
        rd(2'b11, 12'h001, 2'b10, 16'hbeef);
        rd(2'b00, 12'h002, 2'b00, 16'h5566);
        $display("test data done");
    endtask

    task automatic t_prech();
        op(PR, 2'b01, 12'h000, 2'b00, 16'h0000);
        chk4(act, 4'hd);
        rd(2'b11, 12'h401, 2'b00, 16'hbeef);
        chk4(act, 4'h5);
        // read to a closed bank is dropped
        op(RD, 2'b01, 12'h001, 2'b00, 16'h0000);
        chk4({2'b00, oe}, 4'h0);
        chk16(dout, 16'hbeef);
        op(PR, 2'b10, 12'h400, 2'b00, 16'h0000);
        chk4(act, 4'h0);
        // another row of bank zero must not alias the first one
        op(RO, 2'b00, 12'h002, 2'b00, 16'h0000);
        op(WR, 2'b00, 12'h001, 2'b00, 16'h7777);
        op(PR, 2'b00, 12'h000, 2'b00, 16'h0000);
        op(RO, 2'b00, 12'hc01, 2'b00, 16'h0000);
        rd(2'b00, 12'h001, 2'b00, 16'hab34);
        $display("test precharge done");
    endtask

    // ***************************************************************
    // main sequence and watchdog
    // ***************************************************************
    initial begin
        rst_n = 1'b0;
        repeat (16) @(posedge clk_sys);
        @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (3) @(posedge clk_sys);
        #1;
        t_mode();
        t_banks();
        t_data();
        t_prech();
        complete_run();
    end

    // whole run is under 100 cycles, so 500 means a hang
    initial begin
        #50000;
        num_errors++;
        $display("unexpected at %0t: watchdog expired", $time);
        complete_run();
    end
endmodule
